/* uab_pkg.sv */
// constants shared by the serial error-status and baud-divisor block
package uab_pkg;

	localparam int NCH = 2;                      // number of serial channels

	// register byte addresses, one per channel
	localparam logic [31:0] ADDR_MODE   [NCH] = '{32'hFFFF_F300, 32'hFFFF_F310};
	localparam logic [31:0] ADDR_STATUS [NCH] = '{32'hFFFF_F302, 32'hFFFF_F312};
	localparam logic [31:0] ADDR_DIV    [NCH] = '{32'hFFFF_F304, 32'hFFFF_F314};
	localparam logic [31:0] ADDR_SRC_LO [NCH] = '{32'hFFFF_F30E, 32'hFFFF_F31E};
	localparam logic [31:0] ADDR_SRC_HI [NCH] = '{32'hFFFF_F320, 32'hFFFF_F322};
	localparam logic [31:0] ADDR_INV    [NCH] = '{32'hFFFF_F324, 32'hFFFF_F326};

	localparam logic [7:0] REG_RST = 8'h00;      // reset value of every register

	// serial mode register fields
	localparam int MODE_TX_EN  = 7;
	localparam int MODE_RX_EN  = 6;
	localparam int MODE_PS_HI  = 5;
	localparam int MODE_PS_LO  = 4;
	localparam int MODE_LEN8   = 3;
	localparam int MODE_STOP2  = 2;
	localparam int MODE_ISRM   = 1;

	// other field positions
	localparam int INV_BIT     = 0;              // tx_level_invert
	localparam int ST_PARITY   = 2;              // parity error flag
	localparam int ST_FRAMING  = 1;              // framing_error_flag
	localparam int ST_OVERRUN  = 0;              // overrun_error_flag
	localparam int SRC_HI_BIT  = 0;              // top bit of source_select_field
	localparam int SRC_LO_W    = 3;              // low part of source_select_field

	// divisor and source clock encodings
	localparam logic [7:0] DIV_MIN   = 8'h08;    // smallest legal divisor k
	localparam logic [3:0] SRC_EXT   = 4'h0;     // external clock pin
	localparam logic [3:0] SRC_TIMER = 4'h7;     // timer output
	localparam logic [3:0] SRC_LAST  = 4'hB;     // main clock / 512
	localparam int         PRE_W     = 9;        // prescaler width, 2^9 = 512

	// receiver frame states
	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_START  = 3'b001,
		RX_DATA   = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP   = 3'b100
	} uab_rx_state_t;

endpackage : uab_pkg

/* uab_stream_if.sv */
// valid/ready word stream between the receiver and its buffer
`timescale 1ns/10ps
interface uab_stream_if #(parameter int W = 8);
	logic [W-1:0] wdata;   // word offered by the filler
	logic         wvalid;  // filler has a word
	logic         wready;  // buffer can take a word
	logic [W-1:0] rdata;   // word at the buffer head
	logic         rvalid;  // buffer holds a word
	logic         rready;  // drain takes the head word

	modport fill  (output wdata, output wvalid, input wready);
	modport store (input wdata, input wvalid, output wready,
		output rdata, output rvalid, input rready);
	modport drain (input rdata, input rvalid, output rready);
endinterface : uab_stream_if

/* uab_buf.sv */
// small valid/ready buffer holding received characters
`timescale 1ns/10ps
module uab_buf #(
	parameter int W     = 8,   // word width
	parameter int DEPTH = 2    // entries, power of two
) (
	// clock and reset
	input wire logic  ref_clk,
	input wire logic  rst,
	// stream side
	uab_stream_if.store s
);
	// two registered slots, so head data and valid leave straight from flops;
	// limitation: the structure holds two words whatever DEPTH says
	logic [W-1:0] head_r;     // word offered to the reader
	logic [W-1:0] tail_r;     // word waiting behind the head
	logic         head_v_r;   // head slot holds a word
	logic         tail_v_r;   // tail slot holds a word
	logic         push;       // accepted write
	logic         pop;        // accepted read

	assign push     = s.wvalid && !tail_v_r;
	assign pop      = head_v_r && s.rready;
	assign s.wready = !tail_v_r;   // full when both slots hold a word
	assign s.rvalid = head_v_r;
	assign s.rdata  = head_r;

	// data slots; no reset needed on data
	always_ff @(posedge ref_clk) begin
		if (pop) begin
			// push with pop means the tail was empty
			head_r <= push ? s.wdata : tail_r;
		end else if (push && !head_v_r) begin
			head_r <= s.wdata;
		end
		if (push && head_v_r && !pop) begin
			tail_r <= s.wdata;
		end
	end

	// slot occupancy flags
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			head_v_r <= 1'b0;
			tail_v_r <= 1'b0;
		end else if (pop) begin
			head_v_r <= push || tail_v_r;
			tail_v_r <= 1'b0;
		end else if (push) begin
			head_v_r <= 1'b1;
			tail_v_r <= head_v_r;
		end
	end

endmodule : uab_buf

/* uab_ctrl.sv */
// two-channel serial control, receive error status and baud divisor
`timescale 1ns/10ps
module uab_ctrl
	import uab_pkg::*;
#(
	parameter int BUF_DEPTH = 2   // passed to the receive buffer, which holds two entries whatever its value
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// processor memory port
	input  wire logic [31:0]           cpu_addr,
	input  wire logic                  cpu_wr,
	input  wire logic                  cpu_bit_op,
	input  wire logic [2:0]            cpu_bit_sel,
	input  wire logic [7:0]            cpu_wdata,
	input  wire logic                  cpu_rd,
	output      logic [7:0]            cpu_rdata,
	// serial pins
	input  wire logic [uab_pkg::NCH-1:0] serial_rx_pin,
	input  wire logic [uab_pkg::NCH-1:0] ext_clk_pin,
	output      logic [uab_pkg::NCH-1:0] serial_tx_pin,
	// on-chip sources
	input  wire logic [uab_pkg::NCH-1:0] tx_shift_level,
	input  wire logic [uab_pkg::NCH-1:0] timer_out,
	// receive buffer stream, one per channel
	output      logic [7:0]            rx_data   [uab_pkg::NCH],
	output      logic [uab_pkg::NCH-1:0] rx_valid,
	input  wire logic [uab_pkg::NCH-1:0] rx_ready,
	output      logic [uab_pkg::NCH-1:0] rx_done
);
	import uab_pkg::*;

	// software-visible registers
	logic [7:0]       mode_r   [NCH];   // serial_mode_reg
	logic [7:0]       div_r    [NCH];   // baud_divisor_reg
	logic [SRC_LO_W-1:0] src_lo_r [NCH]; // source_clock_select_reg, low
	logic             src_hi_r [NCH];   // source_clock_select_reg, high
	logic             inv_r    [NCH];   // tx_level_invert
	logic [2:0]       status_r [NCH];   // receive_error_status_reg
	logic [7:0]       rdata_r;          // registered read data
	logic [7:0]       rdata_nxt;        // read mux
	logic [PRE_W-1:0] pre_r;            // shared main clock prescaler

	// bit-or-byte write merge
	function automatic logic [7:0] wr_merge(input logic [7:0] old_v);
		logic [7:0] v;
		v = old_v;
		if (cpu_bit_op) begin
			v[cpu_bit_sel] = cpu_wdata[0];
		end else begin
			v = cpu_wdata;
		end
		return v;
	endfunction : wr_merge

	// main clock tick for 2^m division, m from the select code
	function automatic logic pre_tick(input logic [3:0] sel,
		input logic [PRE_W-1:0] pre);
		logic [PRE_W-1:0] mask;
		logic [3:0]       m;
		mask = '0;
		m    = 4'h0;
		if (sel >= 4'h1 && sel <= 4'h6) begin
			m = sel - 4'h1;               // fxx .. fxx/32
		end else begin
			m = sel - 4'h2;               // fxx/64 .. fxx/512
		end
		mask = PRE_W'((10'h001 << m) - 10'h001);
		return (pre & mask) == mask;
	endfunction : pre_tick

	// free-running prescaler feeding every channel's divider
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + PRE_W'(1);
		end
	end

	// read mux over all registers; unmapped reads as zero
	always_comb begin
		rdata_nxt = REG_RST;
		for (int c = 0; c < NCH; c++) begin
			if (cpu_addr == ADDR_MODE[c]) begin
				rdata_nxt = mode_r[c];
			end
			if (cpu_addr == ADDR_STATUS[c]) begin
				rdata_nxt = {5'h00, status_r[c]};
			end
			if (cpu_addr == ADDR_DIV[c]) begin
				rdata_nxt = div_r[c];
			end
			if (cpu_addr == ADDR_SRC_LO[c]) begin
				rdata_nxt = {5'h00, src_lo_r[c]};
			end
			if (cpu_addr == ADDR_SRC_HI[c]) begin
				rdata_nxt = {7'h00, src_hi_r[c]};
			end
			if (cpu_addr == ADDR_INV[c]) begin
				rdata_nxt = {7'h00, inv_r[c]};
			end
		end
	end

	// read data register, one cycle after the read strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= REG_RST;
		end else if (cpu_rd) begin
			rdata_r <= rdata_nxt;
		end
	end
	assign cpu_rdata = rdata_r;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic [2:0]    rx_sync_r;      // rx pin synchroniser plus edge stage
			logic [2:0]    ext_sync_r;     // external clock synchroniser plus edge
			logic [3:0]    src_sel;        // full source_select_field
			logic          src_tick;       // one divider-source tick
			logic [7:0]    kcnt_r;         // divisor counter
			logic          half_tick;      // half bit period elapsed
			logic          phase_r;        // sample on alternate half ticks
			logic          samp;           // bit-centre sample strobe
			logic          line;           // synchronised rx level
			logic          rx_fall;        // start edge
			uab_rx_state_t state_r;        // frame state
			logic [2:0]    bit_idx_r;      // data bit counter
			logic [7:0]    shift_r;        // incoming data
			logic          par_r;          // received parity bit
			logic          complete;       // stop bit sampled
			logic [7:0]    char_data;      // aligned character
			logic          pe;             // parity error of this character
			logic          fe;             // framing error of this character
			logic          ove;            // overrun of this character
			logic          tx_pin_r;       // registered tx pin
			logic          done_r;         // completion pulse
			logic          rx_en;          // receive enable
			logic [1:0]    ps;             // parity mode
			uab_stream_if #(.W(8)) rxs ();

			assign rx_en   = mode_r[ch][MODE_RX_EN];
			assign ps      = mode_r[ch][MODE_PS_HI:MODE_PS_LO];
			assign src_sel = {src_hi_r[ch], src_lo_r[ch]};
			assign line    = rx_sync_r[1];
			assign rx_fall = rx_sync_r[2] && !rx_sync_r[1];

			// register writes for this channel
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					mode_r[ch]   <= REG_RST;
					inv_r[ch]    <= 1'b0;
					div_r[ch]    <= REG_RST;
					src_lo_r[ch] <= '0;
					src_hi_r[ch] <= 1'b0;
				end else if (cpu_wr) begin
					if (cpu_addr == ADDR_MODE[ch]) begin
						mode_r[ch] <= wr_merge(mode_r[ch]) & 8'hFE;
					end
					if (cpu_addr == ADDR_INV[ch] && (!cpu_bit_op || cpu_bit_sel == 3'(INV_BIT))) begin
						inv_r[ch] <= cpu_bit_op ? cpu_wdata[0] : cpu_wdata[INV_BIT];
					end
					// byte writes only; a bit write is ignored
					if (!cpu_bit_op && cpu_addr == ADDR_DIV[ch]) begin
						div_r[ch] <= cpu_wdata;
					end
					if (!cpu_bit_op && cpu_addr == ADDR_SRC_LO[ch]) begin
						src_lo_r[ch] <= cpu_wdata[SRC_LO_W-1:0];
					end
					if (!cpu_bit_op && cpu_addr == ADDR_SRC_HI[ch]) begin
						src_hi_r[ch] <= cpu_wdata[SRC_HI_BIT];
					end
				end
			end

			// pin synchronisers; stage 0 feeds stage 1 only
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					rx_sync_r  <= 3'b111;
					ext_sync_r <= 3'b000;
				end else begin
					rx_sync_r  <= {rx_sync_r[1:0], serial_rx_pin[ch]};
					ext_sync_r <= {ext_sync_r[1:0], ext_clk_pin[ch]};
				end
			end

			// source clock select; codes above the last are dead
			always_comb begin
				if (src_sel == SRC_EXT) begin
					src_tick = ext_sync_r[1] && !ext_sync_r[2];
				end else if (src_sel == SRC_TIMER) begin
					src_tick = timer_out[ch];
				end else if (src_sel <= SRC_LAST) begin
					src_tick = pre_tick(src_sel, pre_r);
				end else begin
					src_tick = 1'b0;
				end
			end

			// divide by k gives a half bit; two halves a bit, so 2^(m+1)*k
			// a prohibited k suppresses every half tick rather than running too fast
			assign half_tick = src_tick && (div_r[ch] >= DIV_MIN)
				&& (kcnt_r == div_r[ch] - 8'h01);
			assign samp = half_tick && phase_r;

			// divisor counter, restarted on a start edge to centre samples
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					kcnt_r  <= 8'h00;
					phase_r <= 1'b0;
				end else if (state_r == RX_IDLE) begin
					kcnt_r  <= 8'h00;
					phase_r <= 1'b1;
				end else if (src_tick) begin
					kcnt_r <= half_tick ? 8'h00 : kcnt_r + 8'h01;
					if (half_tick) begin
						phase_r <= !phase_r;
					end
				end
			end

			// receive frame sequencer
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					state_r   <= RX_IDLE;
					bit_idx_r <= 3'h0;
					shift_r   <= 8'h00;
					par_r     <= 1'b0;
				end else if (!rx_en) begin
					state_r <= RX_IDLE;      // disable aborts a frame
				end else begin
					case (state_r)
						RX_IDLE: begin
							if (rx_fall) begin
								state_r <= RX_START;
							end
						end
						RX_START: begin
							if (samp) begin
								// a high line at mid start is a glitch
								state_r   <= line ? RX_IDLE : RX_DATA;
								bit_idx_r <= 3'h0;
							end
						end
						RX_DATA: begin
							if (samp) begin
								shift_r   <= {line, shift_r[7:1]};
								bit_idx_r <= bit_idx_r + 3'h1;
								if (bit_idx_r == (mode_r[ch][MODE_LEN8] ? 3'h7 : 3'h6)) begin
									state_r <= (ps != 2'b00) ? RX_PARITY : RX_STOP;
								end
							end
						end
						RX_PARITY: begin
							if (samp) begin
								par_r   <= line;
								state_r <= RX_STOP;
							end
						end
						RX_STOP: begin
							// one stop bit only, whatever the stop length
							if (samp) begin
								state_r <= RX_IDLE;
							end
						end
						default: begin
							state_r <= RX_IDLE;
						end
					endcase
				end
			end

			assign complete  = rx_en && (state_r == RX_STOP) && samp;
			assign char_data = mode_r[ch][MODE_LEN8] ? shift_r : {1'b0, shift_r[7:1]};
			// zero-parity mode checks nothing
			assign pe  = ps[1] && ((^{char_data, par_r}) == ps[0]);
			assign fe  = !line;
			// buffer still full means the old word is unread
			assign ove = !rxs.wready;

			// error status, replaced with each character's result
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					status_r[ch] <= 3'b000;
				end else if (complete) begin
					status_r[ch][ST_PARITY]  <= pe;
					status_r[ch][ST_FRAMING] <= fe;
					status_r[ch][ST_OVERRUN] <= ove;
				end
			end

			// completion pulse, held back on error when so configured
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					done_r <= 1'b0;
				end else begin
					done_r <= complete && !(mode_r[ch][MODE_ISRM] && (pe || fe || ove));
				end
			end

			// transmit pin level, optionally inverted
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					tx_pin_r <= 1'b1;
				end else begin
					tx_pin_r <= tx_shift_level[ch] ^ inv_r[ch];
				end
			end

			// received words queue here; a reader stalled past two words loses the newer ones
			assign rxs.wdata  = char_data;
			assign rxs.wvalid = complete;
			assign rxs.rready = rx_ready[ch];

			uab_buf #(
				.W     (8),
				.DEPTH (BUF_DEPTH)
			) u_buf (
				.ref_clk (ref_clk),
				.rst     (rst),
				.s       (rxs)
			);

			assign rx_data[ch]       = rxs.rdata;
			assign rx_valid[ch]      = rxs.rvalid;
			assign rx_done[ch]       = done_r;
			assign serial_tx_pin[ch] = tx_pin_r;
		end
	endgenerate

endmodule : uab_ctrl

/* uab_ctrl_properties.sv */
// concurrent checks on the ports of the serial status and baud divisor block
`timescale 1ns/10ps
module uab_ctrl_properties (
	// clock and reset
	input wire logic                    ref_clk,
	input wire logic                    rst,
	// processor memory port
	input wire logic [31:0]             cpu_addr,
	input wire logic                    cpu_wr,
	input wire logic                    cpu_bit_op,
	input wire logic [2:0]              cpu_bit_sel,
	input wire logic [7:0]              cpu_wdata,
	input wire logic                    cpu_rd,
	input wire logic [7:0]              cpu_rdata,
	// serial pins and receive stream
	input wire logic [uab_pkg::NCH-1:0] serial_tx_pin,
	input wire logic [uab_pkg::NCH-1:0] tx_shift_level,
	input wire logic [7:0]              rx_data [uab_pkg::NCH],
	input wire logic [uab_pkg::NCH-1:0] rx_valid,
	input wire logic [uab_pkg::NCH-1:0] rx_ready,
	input wire logic [uab_pkg::NCH-1:0] rx_done
);
	import uab_pkg::*;

	logic       inv0_r;  // shadow of channel 0 inversion bit
	logic [7:0] div0_r;  // shadow of channel 0 divisor

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// shadow inversion bit: byte write or bit write aimed at bit 0
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			inv0_r <= 1'h0;
		end else if (cpu_wr && cpu_addr == ADDR_INV[0] && (!cpu_bit_op || cpu_bit_sel == 3'h0)) begin
			inv0_r <= cpu_wdata[0];
		end
	end

	// shadow divisor: bit writes must leave it alone
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div0_r <= 8'h00;
		end else if (cpu_wr && !cpu_bit_op && cpu_addr == ADDR_DIV[0]) begin
			div0_r <= cpu_wdata;
		end
	end

	a_tx_pin_level: assert property (
		!$past(rst) |-> serial_tx_pin[0] == ($past(tx_shift_level[0]) ^ $past(inv0_r)))
		else $error("transmit pin level does not follow inversion bit");
	a_inv_read_back: assert property (
		cpu_rd && !cpu_wr && cpu_addr == ADDR_INV[0] |=> cpu_rdata == {7'h00, $past(inv0_r)})
		else $error("inversion register read wrong");
	a_div_read_back: assert property (
		cpu_rd && !cpu_wr && cpu_addr == ADDR_DIV[0] |=> cpu_rdata == $past(div0_r))
		else $error("divisor register read wrong");
	a_status_high_zero: assert property (
		cpu_rd && cpu_addr == ADDR_STATUS[0] |=> cpu_rdata[7:3] == 5'h00)
		else $error("status upper bits not zero");
	a_src_high_zero: assert property (
		cpu_rd && cpu_addr == ADDR_SRC_LO[0] |=> cpu_rdata[7:3] == 5'h00)
		else $error("source select upper bits not zero");
	a_done_single_pulse: assert property (
		rx_done[0] |=> !rx_done[0] [*8])
		else $error("completion pulse too long or too close");
	a_done_word_held: assert property (
		rx_done[0] |-> rx_valid[0])
		else $error("completion without a buffered word");
	a_stall_keeps_word: assert property (
		rx_valid[0] && !rx_ready[0] |=> rx_valid[0] && $stable(rx_data[0]))
		else $error("buffered word lost during stall");
endmodule : uab_ctrl_properties

/* uab_remote_tx.sv */
// remote serial station that sends frames toward the receive pin
`timescale 1ns/10ps
module uab_remote_tx #(
	parameter int BIT_CYC = 16  // clock cycles per serial bit
) (
	// clock
	input wire logic ref_clk,
	// serial line toward the device
	output     logic line
);
	int bit_cyc = BIT_CYC;  // bit time in use; the bench retunes it per source

	// line rests at the mark level between frames
	initial line = 1'h1;

	// hold one level for a whole bit time, changed at the falling edge
	task automatic put_bit(input logic v);
		@(negedge ref_clk);
		line = v;
		repeat (bit_cyc - 1) @(negedge ref_clk);
	endtask : put_bit

	// start, eight data bits lsb first, parity, one stop
	task automatic send(input logic [7:0] d, input logic par, input logic stop);
		put_bit(1'h0);
		for (int i = 0; i < 8; i++) begin
			put_bit(d[i]);
		end
		put_bit(par);
		put_bit(stop);
		// a broken stop must still return the line to rest
		if (!stop) begin
			put_bit(1'h1);
		end
	endtask : send
endmodule : uab_remote_tx

/* uab_ctrl_tb.sv */
// self-checking bench for the serial status and baud divisor block
`timescale 1ns/10ps
module uab_ctrl_tb;
	import uab_pkg::*;

	localparam int K_DIV = 8;  // divisor k, so one bit is 2*k cycles at fxx

	logic        ref_clk = 1'h0;
	logic        rst = 1'h1;
	logic [31:0] cpu_addr = 32'h0000_0000;
	logic        cpu_wr = 1'h0;
	logic        cpu_bit_op = 1'h0;
	logic [2:0]  cpu_bit_sel = 3'h0;
	logic [7:0]  cpu_wdata = 8'h00;
	logic        cpu_rd = 1'h0;
	logic [7:0]  cpu_rdata;
	wire  [1:0]  serial_rx_pin;
	logic [1:0]  ext_clk_pin = 2'h0;
	logic [1:0]  serial_tx_pin;
	logic [1:0]  tx_shift_level = 2'h0;
	logic [1:0]  timer_out = 2'h0;
	logic [7:0]  rx_data [NCH];
	logic [1:0]  rx_valid;
	logic [1:0]  rx_ready = 2'h2;
	logic [1:0]  rx_done;
	logic        rx_line;      // remote station output
	logic [7:0]  n_done = 8'h00;  // completions seen on channel 0
	int          n_errors = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [1:0]  tmr_cnt = 2'h0;  // timer source phase
	logic        tmr_run = 1'h0;  // timer source enabled

	// channel 1 receive line rests high
	assign serial_rx_pin = {1'h1, rx_line};

	uab_ctrl #(.BUF_DEPTH(2)) uut (.ref_clk, .rst, .cpu_addr, .cpu_wr, .cpu_bit_op, .cpu_bit_sel,
		.cpu_wdata, .cpu_rd, .cpu_rdata, .serial_rx_pin, .ext_clk_pin, .serial_tx_pin,
		.tx_shift_level, .timer_out, .rx_data, .rx_valid, .rx_ready, .rx_done);
	uab_remote_tx #(.BIT_CYC(2 * K_DIV)) remote (.ref_clk, .line(rx_line));

	always #5 ref_clk = ~ref_clk;

	// timer source: one high cycle in four while enabled, unlike any fxx rate used
	always @(negedge ref_clk) begin
		tmr_cnt = tmr_cnt + 2'h1;
		timer_out[0] = tmr_run && (tmr_cnt == 2'h3);
	end

	// count completions and cut a hang short
	always @(posedge ref_clk) begin
		if (rx_done[0] === 1'h1) n_done++;
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : chk

	// write strobe held across one rising edge
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
		@(negedge ref_clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_bit_op = b;
		cpu_bit_sel = s;
		cpu_wr = 1'h1;
		@(negedge ref_clk);
		cpu_wr = 1'h0;
	endtask : wr

	// read, then compare the registered answer
	task automatic rc(input logic [31:0] a, input logic [7:0] want);
		@(negedge ref_clk);
		cpu_addr = a;
		cpu_rd = 1'h1;
		@(negedge ref_clk);
		cpu_rd = 1'h0;
		chk(cpu_rdata, want);
	endtask : rc

	// hand one word from channel 0 buffer to the reader
	task automatic take;
		@(negedge ref_clk);
		rx_ready[0] = 1'h1;
		@(negedge ref_clk);
		rx_ready[0] = 1'h0;
	endtask : take

	task automatic end_of_test;
		$display("counts: checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (12) @(negedge ref_clk);
		rst = 1'h0;
		// every register but mode is read back cleared after reset
		for (int c = 0; c < NCH; c++) begin
			rc(ADDR_STATUS[c], 8'h00);
			rc(ADDR_DIV[c], 8'h00);
			rc(ADDR_SRC_LO[c], 8'h00);
			rc(ADDR_SRC_HI[c], 8'h00);
			rc(ADDR_INV[c], 8'h00);
		end
		$display("test reset values done");
		// inversion by bit write, cleared by byte write with upper bits fixed
		wr(ADDR_INV[0], 8'h01, 1'h1, 3'h0);
		rc(ADDR_INV[0], 8'h01);
		tx_shift_level = 2'h3;
		repeat (2) @(negedge ref_clk);
		chk({6'h00, serial_tx_pin}, 8'h02);
		wr(ADDR_INV[0], 8'hFE, 1'h0, 3'h0);
		rc(ADDR_INV[0], 8'h00);
		chk({6'h00, serial_tx_pin}, 8'h03);
		$display("test inversion done");
		// legal divisor first, bit writes refused, source fxx undivided
		wr(ADDR_DIV[0], 8'h08, 1'h0, 3'h0);
		wr(ADDR_DIV[0], 8'h01, 1'h1, 3'h4);
		rc(ADDR_DIV[0], 8'h08);
		wr(ADDR_SRC_LO[0], 8'hF9, 1'h0, 3'h0);
		wr(ADDR_SRC_LO[0], 8'h01, 1'h1, 3'h1);
		rc(ADDR_SRC_LO[0], 8'h01);
		wr(ADDR_STATUS[0], 8'hFF, 1'h0, 3'h0);
		rc(ADDR_STATUS[0], 8'h00);
		wr(32'h0000_1000, 8'h55, 1'h0, 3'h0);
		rc(32'h0000_1000, 8'h00);
		// mode set while idle: receive, even parity, 8 bits, two stops
		wr(ADDR_MODE[0], 8'h7C, 1'h0, 3'h0);
		$display("test registers done");
		// two frames back to back with one stop bit each
		remote.send(8'h5A, ^8'h5A, 1'h1);
		remote.send(8'h3C, ~^8'h3C, 1'h1);
		rc(ADDR_STATUS[0], 8'h04);
		remote.send(8'hC3, ^8'hC3, 1'h1);
		rc(ADDR_STATUS[0], 8'h01);
		remote.send(8'h81, ^8'h81, 1'h0);
		rc(ADDR_STATUS[0], 8'h03);
		chk(n_done, 8'h04);
		chk(rx_data[0], 8'h5A);
		take();
		chk(rx_data[0], 8'h3C);
		take();
		chk({7'h00, rx_valid[0]}, 8'h00);
		remote.send(8'h11, ^8'h11, 1'h1);
		rc(ADDR_STATUS[0], 8'h00);
		chk(rx_data[0], 8'h11);
		take();
		$display("test receive done");
		// idle reconfigure: odd parity, 7 bits, done held back on error, fxx/2
		wr(ADDR_MODE[0], 8'h62, 1'h0, 3'h0);
		wr(ADDR_SRC_LO[0], 8'h02, 1'h0, 3'h0);
		// m = 1 gives 2^(m+1)*k cycles per bit
		remote.bit_cyc = 4 * K_DIV;
		// parity bit rides in the eighth slot, stop in the parity slot
		remote.send({1'h1, 7'h35}, 1'h1, 1'h1);
		rc(ADDR_STATUS[0], 8'h00);
		chk(rx_data[0], 8'h35);
		take();
		remote.send({1'h0, 7'h35}, 1'h1, 1'h1);
		rc(ADDR_STATUS[0], 8'h04);
		chk(n_done, 8'h06);
		take();
		// timer output ticking every fourth cycle feeds the divider
		wr(ADDR_SRC_LO[0], 8'h07, 1'h0, 3'h0);
		tmr_run = 1'h1;
		remote.bit_cyc = 8 * K_DIV;
		remote.send({1'h0, 7'h2A}, 1'h1, 1'h1);
		rc(ADDR_STATUS[0], 8'h00);
		chk(rx_data[0], 8'h2A);
		$display("test source modes done");
		end_of_test();
	end
endmodule : uab_ctrl_tb

bind uab_ctrl uab_ctrl_properties u_props (.ref_clk, .rst, .cpu_addr, .cpu_wr, .cpu_bit_op, .cpu_bit_sel,
	.cpu_wdata, .cpu_rd, .cpu_rdata, .serial_tx_pin, .tx_shift_level, .rx_data, .rx_valid, .rx_ready, .rx_done);
